/* hw/lvd_cfg.svh */
`ifndef LVD_CFG_SVH
`define LVD_CFG_SVH

// bus map
`define LVD_CTRL_OFFSET     12'h000
`define LVD_IRQ_OFFSET      12'h004

// control register fields
`define LVD_STABLE_BIT      5
`define LVD_POWER_BIT       4
`define LVD_LEVEL_MSB       3
`define LVD_LEVEL_LSB       0
`define LVD_CTRL_RESET      8'h05
`define LVD_LEVEL_RESET     4'h5
`define LVD_LEVEL_EXTERNAL  4'hF

// trip / interrupt enable register fields
`define LVD_FLAG_BIT        0
`define LVD_TIE_BIT         1
`define LVD_GIE_BIT         2

// reference settling
`define LVD_CLK_MHZ         50
`define LVD_SETTLE_US       20
`define LVD_SETTLE_CYCLES   ((`LVD_SETTLE_US) * (`LVD_CLK_MHZ))
`define LVD_CNT_W           11

// axi responses
`define LVD_RESP_OKAY       2'h0
`define LVD_RESP_SLVERR     2'h2

`endif

/* hw/lvd_pkg.sv */
package lvd_pkg;

	// what the analog front end is told to do
	typedef struct packed {
		logic       power_on;
		logic       external_select;
		logic [3:0] tap_select;
	} analog_ctrl_t;

	// what the core is told
	typedef struct packed {
		logic wake_request;
		logic resume_at_vector;
		logic interrupt_request;
	} core_event_t;

	typedef enum logic [1:0] {
		settle_off,
		settle_wait,
		settle_done
	} settle_state_t;

endpackage : lvd_pkg

/* hw/low_voltage_detect_control.sv */
`timescale 1ns/1ps
`include "lvd_cfg.svh"

module low_voltage_detect_control (
	input  wire logic                 mclk,
	input  wire logic                 reset,
	input  wire logic [11:0]          s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [11:0]          s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic                 comparator_below,
	input  wire logic                 core_sleeping,
	output lvd_pkg::analog_ctrl_t     analog_ctrl,
	output lvd_pkg::core_event_t      core_event
);

	////////////////////////////////////////////////////////////////////////////////
	// state

	logic                   power_r;
	logic [3:0]             level_r;
	logic                   flag_r;
	logic                   tie_r;
	logic                   gie_r;
	lvd_pkg::settle_state_t settle_r;
	lvd_pkg::settle_state_t settle_nxt;
	logic [`LVD_CNT_W-1:0]  settle_cnt_r;
	logic [`LVD_CNT_W-1:0]  settle_cnt_nxt;

	logic        aw_held_r;
	logic [11:0] aw_addr_r;
	logic        w_held_r;
	logic [31:0] w_data_r;
	logic [3:0]  w_strb_r;
	wire         wr_fire;

	////////////////////////////////////////////////////////////////////////////////
	// write channel capture

	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take  = s_axi_wvalid && s_axi_wready;

	always_ff @(posedge mclk) begin
		if (reset) begin
			aw_held_r <= 1'b0;
		end else if (aw_take) begin
			aw_held_r <= 1'b1;
		end else if (wr_fire) begin
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			aw_addr_r <= 12'h000;
		end else if (aw_take) begin
			aw_addr_r <= s_axi_awaddr;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			w_held_r <= 1'b0;
		end else if (w_take) begin
			w_held_r <= 1'b1;
		end else if (wr_fire) begin
			w_held_r <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			w_data_r <= 32'h0000_0000;
		end else if (w_take) begin
			w_data_r <= s_axi_wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			w_strb_r <= 4'h0;
		end else if (w_take) begin
			w_strb_r <= s_axi_wstrb;
		end
	end

	// address and data may arrive in either order; commit once both are held and no write response is pending
	assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;

	wire [11:0] ctrl_addr = `LVD_CTRL_OFFSET;
	wire [11:0] irq_addr  = `LVD_IRQ_OFFSET;

	wire wr_ctrl = wr_fire && (aw_addr_r[11:2] == ctrl_addr[11:2]);
	wire wr_irq  = wr_fire && (aw_addr_r[11:2] == irq_addr[11:2]);
	wire wr_map  = wr_ctrl || wr_irq;
	wire wr_lane = w_strb_r[0];

	wire ctrl_we = wr_ctrl && wr_lane;
	wire irq_we  = wr_irq && wr_lane;

	always_ff @(posedge mclk) begin
		if (reset) begin
			s_axi_awready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held_r && !aw_take;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= !w_held_r && !w_take;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			s_axi_bvalid <= 1'b0;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			s_axi_bresp <= `LVD_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bresp <= wr_map ? `LVD_RESP_OKAY : `LVD_RESP_SLVERR;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// control register

	always_ff @(posedge mclk) begin
		if (reset) begin
			power_r <= 1'b0;
		end else if (ctrl_we) begin
			power_r <= w_data_r[`LVD_POWER_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			level_r <= `LVD_LEVEL_RESET;
		end else if (ctrl_we) begin
			level_r <= w_data_r[`LVD_LEVEL_MSB:`LVD_LEVEL_LSB];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// reference settling

	wire settle_end = (settle_cnt_r == `LVD_CNT_W'(`LVD_SETTLE_CYCLES - 1));
	wire stable     = (settle_r == lvd_pkg::settle_done);

	always_comb begin
		settle_nxt     = settle_r;
		settle_cnt_nxt = settle_cnt_r;
		unique case (settle_r)
			lvd_pkg::settle_off: begin
				settle_cnt_nxt = '0;
				if (power_r) begin
					settle_nxt = lvd_pkg::settle_wait;
				end
			end
			lvd_pkg::settle_wait: begin
				settle_cnt_nxt = settle_cnt_r + `LVD_CNT_W'(1);
				if (!power_r) begin
					settle_nxt = lvd_pkg::settle_off;
				end else if (settle_end) begin
					settle_nxt = lvd_pkg::settle_done;
				end
			end
			lvd_pkg::settle_done: begin
				settle_cnt_nxt = '0;
				if (!power_r) begin
					settle_nxt = lvd_pkg::settle_off;
				end
			end
			default: begin
				settle_nxt     = lvd_pkg::settle_off;
				settle_cnt_nxt = '0;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			settle_r <= lvd_pkg::settle_off;
		end else begin
			settle_r <= settle_nxt;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			settle_cnt_r <= '0;
		end else begin
			settle_cnt_r <= settle_cnt_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// trip flag and interrupt enables

	// comparator is only trusted once powered and settled
	wire trip_set = power_r && stable && comparator_below;
	wire trip_clr = irq_we && !w_data_r[`LVD_FLAG_BIT];

	always_ff @(posedge mclk) begin
		if (reset) begin
			flag_r <= 1'b0;
		end else begin
			// set beats a clear in the same cycle
			flag_r <= trip_set || (flag_r && !trip_clr);
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			tie_r <= 1'b0;
		end else if (irq_we) begin
			tie_r <= w_data_r[`LVD_TIE_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			gie_r <= 1'b0;
		end else if (irq_we) begin
			gie_r <= w_data_r[`LVD_GIE_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// core events

	wire trip_rise  = trip_set && !flag_r;
	wire wake_event = trip_rise && core_sleeping;

	always_ff @(posedge mclk) begin
		if (reset) begin
			core_event <= '0;
		end else begin
			core_event.wake_request <= wake_event;
			if (wake_event) begin
				core_event.resume_at_vector <= gie_r && tie_r;
			end else if (!core_sleeping) begin
				core_event.resume_at_vector <= 1'b0;
			end
			core_event.interrupt_request <= (trip_set || flag_r) && tie_r && gie_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// analog front end control

	always_ff @(posedge mclk) begin
		if (reset) begin
			analog_ctrl.power_on        <= 1'b0;
			analog_ctrl.external_select <= 1'b0;
			analog_ctrl.tap_select      <= `LVD_LEVEL_RESET;
		end else begin
			analog_ctrl.power_on        <= power_r;
			analog_ctrl.external_select <= (level_r == `LVD_LEVEL_EXTERNAL);
			analog_ctrl.tap_select      <= level_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read channel

	wire [7:0] ctrl_view = {2'b00, stable, power_r, level_r};
	wire [7:0] irq_view  = {5'b00000, gie_r, tie_r, flag_r};

	wire rd_take = s_axi_arvalid && s_axi_arready;
	wire rd_ctrl = (s_axi_araddr[11:2] == ctrl_addr[11:2]);
	wire rd_irq  = (s_axi_araddr[11:2] == irq_addr[11:2]);

	wire [31:0] rd_word = rd_ctrl ? {24'h000000, ctrl_view} :
	                      rd_irq  ? {24'h000000, irq_view}  : 32'h0000_0000;
	wire [1:0]  rd_resp = (rd_ctrl || rd_irq) ? `LVD_RESP_OKAY : `LVD_RESP_SLVERR;

	always_ff @(posedge mclk) begin
		if (reset) begin
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !rd_take;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
		end else if (rd_take) begin
			s_axi_rvalid <= 1'b1;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			s_axi_rdata <= 32'h0000_0000;
		end else if (rd_take) begin
			s_axi_rdata <= rd_word;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			s_axi_rresp <= `LVD_RESP_OKAY;
		end else if (rd_take) begin
			s_axi_rresp <= rd_resp;
		end
	end

endmodule : low_voltage_detect_control

/* verif/lvd_chk.sv */
`timescale 1ns/1ps
module lvd_chk (
	input wire logic                  mclk,
	input wire logic                  reset,
	input wire logic                  s_axi_awvalid,
	input wire logic                  s_axi_arvalid,
	input wire logic                  s_axi_arready,
	input wire logic                  s_axi_rvalid,
	input wire logic [31:0]           s_axi_rdata,
	input wire logic                  core_sleeping,
	input wire lvd_pkg::analog_ctrl_t analog_ctrl,
	input wire lvd_pkg::core_event_t  core_event
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	logic [10:0] on_cnt;
	logic [2:0]  aw_age;
	// cycles since the detector was powered, and since the last write address
	always_ff @(posedge mclk) begin
		on_cnt <= (reset || !analog_ctrl.power_on) ? 11'h0 : on_cnt + {10'h0, on_cnt != 11'h7FF};
		aw_age <= (reset || s_axi_awvalid) ? 3'h0 : aw_age + {2'h0, aw_age != 3'h7};
	end
	property p_top_zero;
		s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0;
	endproperty
	a_top_zero: assert property (p_top_zero) else $error("upper read bits set");
	property p_rst_val;
		$fell(reset) |-> analog_ctrl == 6'h05;
	endproperty
	a_rst_val: assert property (p_rst_val) else $error("analog control not reset");
	property p_ext_sel;
		analog_ctrl.external_select == (analog_ctrl.tap_select == 4'hF);
	endproperty
	a_ext_sel: assert property (p_ext_sel) else $error("external select wrong");
	property p_wake;
		core_event.wake_request |-> $past(core_sleeping) ##1 !core_event.wake_request;
	endproperty
	a_wake: assert property (p_wake) else $error("wake pulse wrong");
	property p_settle;
		core_event.wake_request |-> on_cnt >= 11'h3E8;
	endproperty
	a_settle: assert property (p_settle) else $error("trip before settling");
	property p_vector;
		$rose(core_event.resume_at_vector) |-> core_event.wake_request;
	endproperty
	a_vector: assert property (p_vector) else $error("vector without wake");
	property p_hold;
		core_event.interrupt_request && aw_age == 3'h7 |=> core_event.interrupt_request;
	endproperty
	a_hold: assert property (p_hold) else $error("trip dropped by itself");
	property p_rlat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rlat: assert property (p_rlat) else $error("read answer late");
endmodule : lvd_chk
bind low_voltage_detect_control lvd_chk i_chk (.mclk, .reset, .s_axi_awvalid, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .core_sleeping, .analog_ctrl, .core_event);

/* verif/tb_low_voltage_detect_control.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_low_voltage_detect_control;
	logic                  mclk = 1'h0, reset = 1'h1, core_sleeping = 1'h0, comparator_below = 1'h0;
	logic [11:0]           s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0]           s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]            s_axi_wstrb = 4'hF;
	logic                  s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic                  s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]            s_axi_bresp, s_axi_rresp;
	lvd_pkg::analog_ctrl_t analog_ctrl;
	lvd_pkg::core_event_t  core_event;
	int                    n_fail = 0, comparisons = 0;
	low_voltage_detect_control i_dut (.mclk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .comparator_below, .core_sleeping, .analog_ctrl, .core_event);
	initial forever #10 mclk = ~mclk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic aw_done;
		logic w_done;
		aw_done = 1'h0;
		w_done = 1'h0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		// each channel is released at the edge that takes it
		do begin
			@(posedge mclk);
			if (s_axi_awready && !aw_done) begin
				aw_done = 1'h1;
				s_axi_awvalid <= 1'h0;
			end
			if (s_axi_wready && !w_done) begin
				w_done = 1'h1;
				s_axi_wvalid <= 1'h0;
			end
		end while (!(aw_done && w_done));
		do @(posedge mclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		`CHK(s_axi_bresp, (a > 12'h004) ? 2'h2 : 2'h0)
	endtask : wr
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge mclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge mclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		`CHK(s_axi_rdata, e)
		`CHK(s_axi_rresp, (a > 12'h004) ? 2'h2 : 2'h0)
	endtask : rc
	// one sampled dip of the sensed input while asleep
	task automatic trip(input logic [2:0] e);
		logic [2:0] seen;
		core_sleeping <= 1'h1;
		comparator_below <= 1'h1;
		@(posedge mclk);
		comparator_below <= 1'h0;
		#1 seen = core_event;
		@(posedge mclk);
		#1 `CHK(seen, e)
		`CHK(core_event, e & 3'h3)
		@(posedge mclk);
		core_sleeping <= 1'h0;
	endtask : trip
	task automatic wrap_up;
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#60000 n_fail++;
		wrap_up;
	end
	initial begin
		repeat (12) @(posedge mclk);
		reset <= 1'h0;
		rc(12'h000, 32'h05);
		rc(12'h004, 32'h00);
		wr(12'h000, 32'hEF);
		rc(12'h000, 32'h0F);
		`CHK(analog_ctrl, 6'h1F)
		wr(12'h000, 32'h00);
		rc(12'h000, 32'h00);
		$display("register test done");
		wr(12'h000, 32'h13);
		comparator_below <= 1'h1;
		rc(12'h000, 32'h13);
		repeat (500) @(posedge mclk);
		comparator_below <= 1'h0;
		rc(12'h004, 32'h00);
		repeat (600) @(posedge mclk);
		rc(12'h000, 32'h33);
		`CHK(analog_ctrl, 6'h23)
		$display("settle test done");
		wr(12'h004, 32'h06);
		trip(3'h7);
		rc(12'h004, 32'h07);
		`CHK(core_event, 3'h1)
		wr(12'h004, 32'h00);
		rc(12'h004, 32'h00);
		wr(12'h004, 32'h02);
		trip(3'h4);
		$display("event test done");
		wr(12'h000, 32'h03);
		rc(12'h000, 32'h03);
		rc(12'h008, 32'h00);
		wr(12'h008, 32'h00);
		wr(12'h000, 32'h1A);
		reset <= 1'h1;
		@(posedge mclk);
		reset <= 1'h0;
		rc(12'h000, 32'h05);
		rc(12'h004, 32'h00);
		$display("reset test done");
		wrap_up;
	end
endmodule : tb_low_voltage_detect_control
